// ===== pkg/tss_pkg.sv
package tss_pkg;

    // Link and frame geometry.
    localparam int LINKS = 8;
    localparam int SLOTS = 32;
    localparam int PIN_COUNT = 27;

    // Time bases count master clocks: [8:4] slot, [3:1] bit, [0] half bit.
    localparam logic [8:0] IN_BASE_PRESET = 9'h000;
    localparam logic [8:0] BASE_OFFSET = 9'h020;
    localparam logic [8:0] OUT_BASE_PRESET = IN_BASE_PRESET + BASE_OFFSET;
    localparam logic [3:0] SLOT_LAST_PHASE = 4'hf;
    localparam logic [8:0] EXTRACT_CNT = 9'h010;

    // Connection memory word.
    localparam int CM_SRC_BIT = 8;
    localparam logic [8:0] CM_IDLE = 9'h1ff;

    // Instruction codes.
    localparam logic [4:0] OP_NONE = 5'h00;
    localparam logic [4:0] OP_CONNECT = 5'h01;
    localparam logic [4:0] OP_DISCONNECT = 5'h02;
    localparam logic [4:0] OP_INSERT = 5'h03;
    localparam logic [4:0] OP_READ_SAMPLE = 5'h04;
    localparam logic [4:0] OP_READ_CM = 5'h05;
    localparam logic [4:0] OP_EXTRACT = 5'h06;

    // Execution timing in master clocks.
    localparam logic [2:0] EXEC_CYCLES = 3'h4;
    localparam logic [1:0] DR_PULSE = 2'h2;

    // Field positions of the opcode readback register.
    localparam int OR2_OP_LSB = 5;
    localparam int OR2_MATCH = 4;
    localparam int OR2_SRC = 3;
    localparam int OR2_BAD = 2;
    localparam int OR2_EXT_DONE = 1;
    localparam int OR2_BUSY = 0;

endpackage

// ===== hdl/pin_sync.sv
// Two-stage synchroniser for a group of pins; each bit is independent.
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Pins and synchronised copy
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] synced
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_st_t;

    sync_st_t q;
    sync_st_t d;

    always_comb begin
        d.meta = pins;
        d.stable = q.meta;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            q <= {INIT, INIT};
        end else begin
            q <= d;
        end
    end

    assign synced = q.stable;
endmodule

// ===== hdl/pcm_deser.sv
// Serial to parallel conversion for all input links, MSB (sign bit) first.
module pcm_deser
    import tss_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Synchronised links and input time base
    input wire logic [LINKS-1:0] pcm_in,
    input wire logic [8:0] bit_cnt,
    // Completed bytes of the slot just ended
    output logic [LINKS-1:0][7:0] word_bytes,
    output logic word_valid,
    output logic [4:0] word_slot
);
    typedef struct packed {
        logic [LINKS-1:0][7:0] shift;
        logic [LINKS-1:0][7:0] bytes;
        logic valid;
        logic [4:0] slot;
    } deser_st_t;

    deser_st_t q;
    deser_st_t d;

    always_comb begin
        d = q;
        d.valid = 1'b0;
        // Sample in the second half of each bit, well clear of the edges.
        if (bit_cnt[0]) begin
            for (int l = 0; l < LINKS; l++) begin
                d.shift[l] = {q.shift[l][6:0], pcm_in[l]};
            end
        end
        if (bit_cnt[3:0] == SLOT_LAST_PHASE) begin
            d.bytes = d.shift;
            d.valid = 1'b1;
            d.slot = bit_cnt[8:4];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign word_bytes = q.bytes;
    assign word_valid = q.valid;
    assign word_slot = q.slot;
endmodule

// ===== hdl/switch_matrix.sv
module switch_matrix
    import tss_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Device control pins
    input wire logic dev_reset_n,
    input wire logic frame_sync_n,
    // Host port strobes and selects
    input wire logic chip_sel_a_n,
    input wire logic chip_sel_b_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic cmd_sel,
    // Multichip match pins
    input wire logic match_addr_a,
    input wire logic match_sel_a,
    input wire logic match_addr_b,
    input wire logic match_sel_b,
    // Host data bus
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic data_ready_n,
    // PCM links; outputs are open drain
    input wire logic [LINKS-1:0] pcm_in,
    output logic [LINKS-1:0] pcm_out,
    output logic [LINKS-1:0] pcm_oe
);
    typedef struct packed {
        logic [255:0][7:0] speech_memory;
        logic [255:0][8:0] connection_memory;
        logic [8:0] in_cnt;
        logic [8:0] out_cnt;
        logic fs_prev;
        logic wr_prev;
        logic rd_prev;
        logic [3:0][4:0] stack;
        logic [4:0] instr;
        logic inst_match;
        logic busy;
        logic [2:0] exec_cnt;
        logic bad;
        logic [1:0] dr_cnt;
        logic dr_n;
        logic [7:0] memory_readback_reg;
        logic [7:0] opcode_readback_reg;
        logic ext_pend;
        logic ext_armed;
        logic ext_done;
        logic [2:0] ext_link;
        logic [LINKS-1:0][7:0] out_shift;
        logic [LINKS-1:0] link_active;
        logic [LINKS-1:0] pcm_oe;
        logic [LINKS-1:0] pcm_low;
        logic [7:0] dout;
        logic doe;
    } st_t;

    st_t q;
    st_t d;

    logic dev_rst_s, fs_s, csa_s, csb_s, wr_s, rd_s, cmd_s;
    logic ma_s, msa_s, mb_s, msb_s;
    logic [7:0] din_s;
    logic [LINKS-1:0] pcm_s;
    logic [PIN_COUNT-1:0] synced;
    logic [LINKS-1:0][7:0] word_bytes;
    logic word_valid;
    logic [4:0] word_slot;
    logic sel, match_s, wr_rise, rd_rise, capture, exec_now;
    logic [7:0] exec_idx;
    logic [4:0] exec_op;

    function automatic st_t idle_state();
        st_t s;
        s = '0;
        s.connection_memory = {256{CM_IDLE}};
        s.in_cnt = IN_BASE_PRESET;
        s.out_cnt = OUT_BASE_PRESET;
        s.fs_prev = 1'b1;
        s.wr_prev = 1'b1;
        s.rd_prev = 1'b1;
        s.dr_n = 1'b1;
        return s;
    endfunction

    // Output link and channel addressed by the stack; 4-byte codes sit deeper.
    function automatic logic [7:0] out_index(input logic [4:0] op, input logic [3:0][4:0] stk);
        if (op == OP_CONNECT || op == OP_INSERT) begin
            return {stk[2][2:0], stk[3]};
        end
        return {stk[0][2:0], stk[1]};
    endfunction

    function automatic logic [4:0] effective_op(input logic [4:0] op, input logic matched);
        if (matched || op == OP_READ_CM) begin
            return op;
        end
        if (op == OP_CONNECT || op == OP_INSERT) begin
            return OP_DISCONNECT;
        end
        return OP_NONE;
    endfunction

    function automatic logic [7:0] source_byte(input logic [8:0] w, input logic [255:0][7:0] sm);
        return w[CM_SRC_BIT] ? w[7:0] : sm[w[7:0]];
    endfunction

    // Every pin crosses into core_clk; idle levels avoid false edges after reset.
    pin_sync #(
        .WIDTH(PIN_COUNT),
        .INIT({PIN_COUNT{1'b1}})
    ) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .pins({dev_reset_n, frame_sync_n, chip_sel_a_n, chip_sel_b_n, wr_n, rd_n, cmd_sel,
               match_addr_a, match_sel_a, match_addr_b, match_sel_b, data_in, pcm_in}),
        .synced(synced)
    );

    assign {dev_rst_s, fs_s, csa_s, csb_s, wr_s, rd_s, cmd_s, ma_s, msa_s, mb_s, msb_s, din_s, pcm_s} = synced;

    pcm_deser u_deser (
        .core_clk(core_clk),
        .reset(reset),
        .pcm_in(pcm_s),
        .bit_cnt(q.in_cnt),
        .word_bytes(word_bytes),
        .word_valid(word_valid),
        .word_slot(word_slot)
    );

    assign sel = !csa_s && !csb_s;
    assign match_s = (ma_s == msa_s) && (mb_s == msb_s);
    assign wr_rise = wr_s && !q.wr_prev;
    assign rd_rise = rd_s && !q.rd_prev;
    // A write overlapping a read is a bus fault and is thrown away.
    assign capture = wr_rise && sel && rd_s && dev_rst_s;
    assign exec_now = q.busy && q.exec_cnt == 3'h1;
    assign exec_idx = out_index(q.instr, q.stack);
    assign exec_op = effective_op(q.instr, q.inst_match);

    always_comb begin
        d = q;
        d.fs_prev = fs_s;
        d.wr_prev = wr_s;
        d.rd_prev = rd_s;

        // Both bases free-run and are pulled to their presets by a low-going sync.
        if (q.fs_prev && !fs_s) begin
            d.in_cnt = IN_BASE_PRESET;
            d.out_cnt = OUT_BASE_PRESET;
        end else begin
            d.in_cnt = q.in_cnt + 9'h001;
            d.out_cnt = q.out_cnt + 9'h001;
        end

        if (word_valid) begin
            for (int l = 0; l < LINKS; l++) begin
                d.speech_memory[{3'(l), word_slot}] = word_bytes[l];
            end
        end

        // Output side: one memory look-up per link at slot start; the rest is spare.
        if (q.out_cnt[3:0] == 4'h0) begin
            for (int l = 0; l < LINKS; l++) begin
                d.link_active[l] = q.connection_memory[{3'(l), q.out_cnt[8:4]}] != CM_IDLE;
                d.out_shift[l] = source_byte(q.connection_memory[{3'(l), q.out_cnt[8:4]}],
                                             q.speech_memory);
            end
        end else if (!q.out_cnt[0]) begin
            for (int l = 0; l < LINKS; l++) begin
                d.out_shift[l] = {q.out_shift[l][6:0], 1'b1};
            end
        end
        for (int l = 0; l < LINKS; l++) begin
            d.pcm_oe[l] = d.link_active[l] && !d.out_shift[l][7];
        end
        d.pcm_low = '0;

        if (q.dr_cnt != 2'h0) begin
            d.dr_cnt = q.dr_cnt - 2'h1;
        end
        if (q.busy) begin
            d.exec_cnt = q.exec_cnt - 3'h1;
        end

        if (capture) begin
            if (!cmd_s) begin
                d.stack = {q.stack[2:0], din_s[4:0]};
            end else begin
                d.instr = din_s[4:0];
                d.inst_match = match_s;
                if (din_s[4:0] == OP_NONE || din_s[4:0] > OP_EXTRACT) begin
                    d.bad = 1'b1;
                end else begin
                    d.bad = 1'b0;
                    d.busy = 1'b1;
                    d.exec_cnt = EXEC_CYCLES;
                end
            end
        end

        if (exec_now) begin
            d.busy = 1'b0;
            unique case (exec_op)
                OP_CONNECT: d.connection_memory[exec_idx] = {1'b0, q.stack[0][2:0], q.stack[1]};
                OP_DISCONNECT: d.connection_memory[exec_idx] = CM_IDLE;
                OP_INSERT: d.connection_memory[exec_idx] = {1'b1, q.stack[0][2:0], q.stack[1]};
                OP_READ_SAMPLE: d.memory_readback_reg = source_byte(q.connection_memory[exec_idx],
                                                                    q.speech_memory);
                OP_READ_CM: begin
                    d.memory_readback_reg = q.connection_memory[exec_idx][7:0];
                    if (q.connection_memory[exec_idx] != CM_IDLE) begin
                        d.dr_cnt = DR_PULSE;
                    end
                end
                OP_EXTRACT: begin
                    d.ext_pend = 1'b1;
                    d.ext_armed = 1'b0;
                    d.ext_link = q.stack[0][2:0];
                end
                default: ;
            endcase
        end

        // Extraction waits for an opcode readback, so it never delays short commands.
        if (rd_rise && sel && cmd_s) begin
            d.ext_armed = q.ext_pend;
        end
        if (q.ext_armed && q.in_cnt == EXTRACT_CNT) begin
            d.memory_readback_reg = q.speech_memory[{q.ext_link, 5'h00}];
            d.ext_pend = 1'b0;
            d.ext_armed = 1'b0;
            d.ext_done = 1'b1;
            d.dr_cnt = DR_PULSE;
        end

        d.opcode_readback_reg = 8'h00;
        d.opcode_readback_reg[7:OR2_OP_LSB] = d.instr[2:0];
        d.opcode_readback_reg[OR2_MATCH] = d.inst_match;
        d.opcode_readback_reg[OR2_SRC] = d.memory_readback_reg == q.connection_memory[exec_idx][7:0]
                                         && q.connection_memory[exec_idx][CM_SRC_BIT];
        d.opcode_readback_reg[OR2_BAD] = d.bad;
        d.opcode_readback_reg[OR2_EXT_DONE] = d.ext_done;
        d.opcode_readback_reg[OR2_BUSY] = d.busy || d.ext_pend;

        d.dr_n = !(d.bad || d.dr_cnt != 2'h0);
        d.doe = !rd_s && sel && wr_s && match_s;
        d.dout = cmd_s ? q.opcode_readback_reg : q.memory_readback_reg;

        if (!dev_rst_s) begin
            d = idle_state();
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            q <= idle_state();
        end else begin
            q <= d;
        end
    end

    assign data_out = q.dout;
    assign data_oe = q.doe;
    assign data_ready_n = q.dr_n;
    assign pcm_out = q.pcm_low;
    assign pcm_oe = q.pcm_oe;

    localparam int DR_LO = 3;
    localparam int DR_HI = 11;
    logic cap_active5;
    assign cap_active5 = capture && cmd_s && din_s[4:0] == OP_READ_CM
                         && q.connection_memory[out_index(OP_READ_CM, q.stack)] != CM_IDLE;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    a_bus_quiet_reset: assert property (!dev_rst_s |=> !data_oe && q.stack == '0)
        else $error("bus active during device reset");
    a_read_needs_match: assert property (data_oe |-> $past(match_s && sel && !rd_s))
        else $error("bus driven without matched selected read");
    a_ignore_unselected: assert property (wr_rise && !sel |=> $stable(q.stack) && $stable(q.instr))
        else $error("unselected write changed stack");
    a_invalid_holds_low: assert property (q.bad |-> !data_ready_n)
        else $error("ready high with invalid opcode");
    a_dr_pulse_len: assert property ($fell(data_ready_n) && !q.bad |=>
        !data_ready_n ##1 (data_ready_n || q.bad || q.dr_cnt == DR_PULSE))
        else $error("ready pulse not two cycles");
    a_dr_after_op5: assert property (cap_active5 |-> ##[DR_LO:DR_HI] !data_ready_n)
        else $error("ready pulse missing after control word read");
    a_preset_on_sync: assert property (q.fs_prev && !fs_s && dev_rst_s |=>
        q.in_cnt == IN_BASE_PRESET && q.out_cnt == OUT_BASE_PRESET)
        else $error("time bases not preset by sync");
    a_base_offset: assert property (q.out_cnt == 9'(q.in_cnt + BASE_OFFSET))
        else $error("time base offset wrong");
    a_cm_cleared: assert property (!dev_rst_s |=>
        q.connection_memory[0] == CM_IDLE && q.connection_memory[255] == CM_IDLE && pcm_oe == '0)
        else $error("connection memory not cleared");
    a_unmatched_drop: assert property (exec_now && !q.inst_match && q.instr == OP_DISCONNECT |=>
        $stable(q.connection_memory))
        else $error("unmatched disconnect executed");

    c_op5_pulse: cover property (cap_active5 ##[DR_LO:DR_HI] !data_ready_n);
    c_bad_opcode: cover property ($rose(q.bad));
    c_extract: cover property (q.ext_armed ##1 q.ext_done && !q.ext_armed);
    c_matched_read: cover property ($rose(data_oe));
endmodule

// ===== tb/pcm_far_end.sv
module pcm_far_end
    import tss_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Switch outputs, open drain
    input wire logic [LINKS-1:0] pcm_out,
    input wire logic [LINKS-1:0] pcm_oe,
    // Frame marker, serial input links and resolved output links
    output logic frame_sync_n,
    output logic [LINKS-1:0] pcm_in,
    output logic [LINKS-1:0] pcm_line
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [8:0] tick_q;
    logic [15:0] lfsr_q;

    // The links carry pull-ups, so a released link reads as ones.
    assign pcm_line = ~pcm_oe | pcm_out;
    // One low clock marks the start of every 512-clock frame.
    assign frame_sync_n = (tick_q != 9'h1ff);
    assign pcm_in = lfsr_q[7:0];

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tick_q <= 9'h000;
            lfsr_q <= 16'hace1;
        end else begin
            tick_q <= tick_q + 9'h001;
            if (tick_q[0]) begin
                lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            end
        end
    end
endmodule

// ===== tb/tb_top.sv
module tb_top
    import tss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {logic [7:0] mask; logic [7:0] val;} note_t;

    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic dev_reset_n = 1'b1;
    logic chip_sel_a_n = 1'b1;
    logic chip_sel_b_n = 1'b1;
    logic wr_n = 1'b1;
    logic rd_n = 1'b1;
    logic cmd_sel = 1'b0;
    logic match_addr_a = 1'b0;
    logic match_sel_a = 1'b0;
    logic match_addr_b = 1'b0;
    logic match_sel_b = 1'b0;
    logic [7:0] data_in = 8'h00;
    logic [7:0] data_out;
    logic data_oe;
    logic data_ready_n;
    logic cs_off = 1'b0;
    logic oe_q = 1'b0;
    logic frame_sync_n;
    logic [LINKS-1:0] pcm_in;
    logic [LINKS-1:0] pcm_out;
    logic [LINKS-1:0] pcm_oe;
    logic [LINKS-1:0] pcm_line;
    logic [4:0] ch;
    logic [2:0] lk;
    logic [7:0] val;
    int error_cnt = 0;
    int total_checks = 0;
    int seed = 25779;
    note_t notes[$];

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    switch_matrix u_switch_matrix (.core_clk(core_clk), .reset(reset), .dev_reset_n(dev_reset_n),
        .frame_sync_n(frame_sync_n), .chip_sel_a_n(chip_sel_a_n), .chip_sel_b_n(chip_sel_b_n),
        .wr_n(wr_n), .rd_n(rd_n), .cmd_sel(cmd_sel), .match_addr_a(match_addr_a),
        .match_sel_a(match_sel_a), .match_addr_b(match_addr_b), .match_sel_b(match_sel_b),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .data_ready_n(data_ready_n),
        .pcm_in(pcm_in), .pcm_out(pcm_out), .pcm_oe(pcm_oe));

    pcm_far_end u_pcm_far_end (.core_clk(core_clk), .reset(reset), .pcm_out(pcm_out), .pcm_oe(pcm_oe),
        .frame_sync_n(frame_sync_n), .pcm_in(pcm_in), .pcm_line(pcm_line));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Equal pairs give a match; the random common value shows either level works.
    task automatic set_match(input bit m);
        logic [1:0] r;
        r = 2'($random(seed));
        match_addr_a <= r[0];
        match_sel_a <= r[0];
        match_addr_b <= r[1];
        match_sel_b <= r[1] ^ !m;
    endtask

    // The upper three bits are random because the device must drop them.
    task automatic wr(input logic cmd, input logic [4:0] d);
        @(posedge core_clk);
        chip_sel_a_n <= cs_off;
        chip_sel_b_n <= 1'b0;
        cmd_sel <= cmd;
        data_in <= {3'($random(seed)), d};
        wr_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        wr_n <= 1'b1;
    endtask

    // Ready: 0 stays high, 1 one short pulse in 5..14 clocks, 2 held low, 3 not judged.
    task automatic op(input logic [4:0] code, input logic [4:0] b[4], input int n, input bit m,
                      input int want);
        int first;
        int lows;
        first = 0;
        lows = 0;
        set_match(m);
        for (int i = 0; i < n; i++) begin
            wr(1'b0, b[i]);
            repeat (6) @(posedge core_clk);
        end
        wr(1'b1, code);
        for (int k = 1; k <= 16; k++) begin
            @(posedge core_clk);
            #1;
            if (data_ready_n === 1'b0) begin
                lows++;
                if (first == 0) first = k;
            end
        end
        if (want != 3) begin
            chk({7'h00, (want == 0) ? lows == 0 : (want == 2) ? lows >= 10 :
                 (first >= 5 && first <= 14 && lows > 0 && lows <= 2)}, 8'h01);
        end
    endtask

    task automatic rd(input logic cmd, input bit m, input logic [7:0] mask, input logic [7:0] exp);
        int seen;
        bit drive;
        seen = 0;
        drive = m && (dev_reset_n === 1'b1);
        if (drive) notes.push_back('{mask, exp});
        @(posedge core_clk);
        set_match(m);
        chip_sel_a_n <= 1'b0;
        chip_sel_b_n <= 1'b0;
        cmd_sel <= cmd;
        rd_n <= 1'b0;
        repeat (6) begin
            @(posedge core_clk);
            #1;
            if (data_oe === 1'b1) seen++;
        end
        chk({7'h00, seen != 0}, {7'h00, drive});
        @(posedge core_clk);
        rd_n <= 1'b1;
        repeat (6) @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin : watch_bus
        note_t nt;
        oe_q <= data_oe;
        if (data_oe === 1'b1 && oe_q !== 1'b1) begin
            if (notes.size() == 0) begin
                chk(data_out, 8'hxx);
            end else begin
                nt = notes.pop_front();
                chk(data_out & nt.mask, nt.val & nt.mask);
            end
        end
    end

    initial begin
        repeat (40000) @(posedge core_clk);
        error_cnt++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
        summarize();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        chk({data_oe, data_ready_n, 6'h00}, 8'h40);
        chk(pcm_line, 8'hff);
        $display("test reset done");
        cs_off = 1'b1;
        op(OP_NONE, '{5'h00, 5'h00, 5'h00, 5'h00}, 0, 1, 0);
        cs_off = 1'b0;
        for (int i = 0; i < 2; i++) begin
            op(i == 0 ? OP_NONE : 5'h07, '{5'h00, 5'h00, 5'h00, 5'h00}, 0, 1, 2);
            op(OP_DISCONNECT, '{5'h00, 5'h00, 5'h00, 5'h00}, 2, 1, 3);
        end
        op(OP_READ_CM, '{5'h00, 5'h00, 5'h00, 5'h00}, 2, 1, 0);
        $display("test opcode check done");
        repeat (3) begin
            ch = 5'($random(seed));
            lk = 3'($random(seed));
            val = {1'b0, 7'($random(seed))};
            op(OP_INSERT, '{ch, {2'b00, lk}, val[4:0], {2'b00, val[7:5]}}, 4, 1, 0);
            op(OP_READ_CM, '{ch, {2'b00, lk}, 5'h00, 5'h00}, 2, 1, 1);
            rd(1'b0, 1'b1, 8'hff, val);
        end
        op(OP_READ_CM, '{ch, {2'b00, lk}, 5'h00, 5'h00}, 2, 0, 1);
        rd(1'b1, 1'b1, 8'hfc, {3'b101, 1'b0, 1'b1, 1'b0, 2'b00});
        $display("test insert and readback done");
        op(OP_DISCONNECT, '{ch, {2'b00, lk}, 5'h00, 5'h00}, 2, 0, 0);
        op(OP_READ_CM, '{ch, {2'b00, lk}, 5'h00, 5'h00}, 2, 1, 1);
        rd(1'b0, 1'b1, 8'hff, val);
        op(OP_INSERT, '{ch, {2'b00, lk}, 5'h15, 5'h02}, 4, 0, 0);
        op(OP_READ_CM, '{ch, {2'b00, lk}, 5'h00, 5'h00}, 2, 1, 0);
        rd(1'b0, 1'b1, 8'hff, 8'hff);
        rd(1'b1, 1'b0, 8'h00, 8'h00);
        $display("test unmatched done");
        // Extraction waits for an opcode readback and then for channel zero of the next frame.
        op(OP_EXTRACT, '{5'h00, {2'b00, lk}, 5'h00, 5'h00}, 2, 1, 3);
        rd(1'b1, 1'b1, 8'he7, 8'hc1);
        repeat (600) @(posedge core_clk);
        rd(1'b1, 1'b1, 8'h03, 8'h02);
        $display("test extraction done");
        op(OP_INSERT, '{ch, {2'b00, lk}, val[4:0], {2'b00, val[7:5]}}, 4, 1, 0);
        @(posedge core_clk);
        dev_reset_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(1'b0, 1'b1, 8'h00, 8'h00);
        op(5'h07, '{5'h00, 5'h00, 5'h00, 5'h00}, 0, 1, 0);
        @(posedge core_clk);
        dev_reset_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        op(OP_READ_CM, '{ch, {2'b00, lk}, 5'h00, 5'h00}, 2, 1, 0);
        rd(1'b0, 1'b1, 8'hff, 8'hff);
        $display("test device reset done");
        summarize();
    end
endmodule
